// file: common/bldc_pkg.sv
// What this block does
// - oscillator set pulse sets both latches
// - ramp above command clears upper latch
// - pwm chopping only on bottom drives
// - current limit clears lower latch until next set
// - each oscillator cycle is a separate event
// - at most one conduction pulse per cycle
// - select high means 60, low means 120 decoding
// - 60 degree code to step mapping
// - 120 degree code to step mapping
// - forward step drive pairs top and bottom
// - reverse swaps top and bottom phase letters
// - top drives active low, bottom active high
// - invalid sensor code turns all drives off
// - run enable low makes motor coast
// - current sense high forces all drives off
// - either undervoltage fault forces all drives off
// - run enable defaults to enabled
package bldc_pkg;

  // register byte offsets on the axi4-lite port
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] OC_COUNT_OFS = 4'h8;

  // control register fields and values after reset
  localparam int CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RST = 1'b1;

  // status register field positions
  localparam int ST_STEP_LSB = 0;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_UPPER_BIT = 4;
  localparam int ST_LOWER_BIT = 5;
  localparam int ST_UV_BIT = 6;
  localparam int ST_DIR_BIT = 7;
  localparam int ST_SEL_BIT = 8;
  localparam int ST_EN_BIT = 9;

  // positions inside the synchronizer vector
  localparam int SYN_A = 2;
  localparam int SYN_B = 1;
  localparam int SYN_C = 0;
  localparam int SYN_DIR = 3;
  localparam int SYN_SEL = 4;
  localparam int SYN_EN = 5;
  localparam int SYN_W = 6;

  // synchronizer reset value: run enable reads as enabled
  localparam logic [5:0] SYN_RST = 6'h20;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verilog/bldc_commutation_pwm.sv
`timescale 1ns/1ps
`default_nettype none

module bldc_commutation_pwm
  import bldc_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // rotor sensors and control pins
  input wire logic rotor_sensor_a,
  input wire logic rotor_sensor_b,
  input wire logic rotor_sensor_c,
  input wire logic fwd_rev,
  input wire logic phase_60_sel,
  input wire logic run_enable,
  // oscillator and comparators
  input wire logic osc_set,
  input wire logic pwm_cmp,
  input wire logic cur_limit,
  input wire logic uv_supply,
  input wire logic uv_ref,
  // bridge drives
  output logic high_side_drive_a,
  output logic high_side_drive_b,
  output logic high_side_drive_c,
  output logic low_side_drive_a,
  output logic low_side_drive_b,
  output logic low_side_drive_c,
  // axi4-lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // counter width must hold at least one bit and fit the data bus
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
    $error("COUNT_W must lie between 1 and 32");
  end

  typedef struct packed {
    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic upper;
    logic lower;
    logic [2:0] top_n;
    logic [2:0] bot;
    logic allow;
    logic [COUNT_W-1:0] oc_count;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

  state_s state_q;
  state_s state_d;

  // rotor code (A,B,C) to step 1..6, zero for an invalid code
  function automatic logic [2:0] decode_step(input logic [2:0] code, input logic sel60);
    logic [2:0] step;
    step = 3'h0;
    if (sel60) begin
      case (code)
        3'h4: step = 3'h1;
        3'h6: step = 3'h2;
        3'h7: step = 3'h3;
        3'h3: step = 3'h4;
        3'h1: step = 3'h5;
        3'h0: step = 3'h6;
        default: step = 3'h0;
      endcase
    end else begin
      case (code)
        3'h4: step = 3'h1;
        3'h6: step = 3'h2;
        3'h2: step = 3'h3;
        3'h3: step = 3'h4;
        3'h1: step = 3'h5;
        3'h5: step = 3'h6;
        default: step = 3'h0;
      endcase
    end
    return step;
  endfunction

  // step to one-hot phase pair {top, bottom}, bit0 = A, bit1 = B, bit2 = C
  function automatic logic [5:0] step_pair(input logic [2:0] step);
    logic [5:0] pair;
    pair = 6'h00;
    case (step)
      3'h1: pair = {3'h1, 3'h4};
      3'h2: pair = {3'h2, 3'h4};
      3'h3: pair = {3'h2, 3'h1};
      3'h4: pair = {3'h4, 3'h1};
      3'h5: pair = {3'h4, 3'h2};
      3'h6: pair = {3'h1, 3'h2};
      default: pair = 6'h00;
    endcase
    return pair;
  endfunction

  // decoded view of the synchronized inputs
  logic [2:0] code;
  logic [2:0] step;
  logic [5:0] pair;
  logic [2:0] top_on;
  logic [2:0] bot_on;
  logic uv_any;
  logic drive_ok;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;

  assign code = {state_q.sync2[SYN_A], state_q.sync2[SYN_B], state_q.sync2[SYN_C]};
  assign step = decode_step(code, state_q.sync2[SYN_SEL]);
  assign pair = step_pair(step);
  assign uv_any = uv_supply | uv_ref;
  // reverse exchanges the letters of the active top and bottom drive
  assign top_on = state_q.sync2[SYN_DIR] ? pair[5:3] : pair[2:0];
  assign bot_on = state_q.sync2[SYN_DIR] ? pair[2:0] : pair[5:3];
  // any lockout kills both banks; the comparator is a sampled level
  assign drive_ok = state_q.sync2[SYN_EN] & state_q.allow & ~uv_any & ~cur_limit
                    & (step != 3'h0);

  // write accepted only with address and data together and no response pending
  assign wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~state_q.bvalid;
  assign rd_go = ce & s_axi_arvalid & ~state_q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_hit = (s_axi_awaddr == CTRL_OFS) || (s_axi_awaddr == OC_COUNT_OFS);

  // status picture of the commutation core
  always_comb begin
    status_word = 32'h0;
    status_word[ST_STEP_LSB +: 3] = step;
    status_word[ST_VALID_BIT] = (step != 3'h0);
    status_word[ST_UPPER_BIT] = state_q.upper;
    status_word[ST_LOWER_BIT] = state_q.lower;
    status_word[ST_UV_BIT] = uv_any;
    status_word[ST_DIR_BIT] = state_q.sync2[SYN_DIR];
    status_word[ST_SEL_BIT] = state_q.sync2[SYN_SEL];
    status_word[ST_EN_BIT] = state_q.sync2[SYN_EN];
  end

  // read mux; unmapped offsets answer zero with slverr
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: rd_word[CTRL_ALLOW_BIT] = state_q.allow;
      STATUS_OFS: rd_word = status_word;
      OC_COUNT_OFS: rd_word[COUNT_W-1:0] = state_q.oc_count;
      default: rd_hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    state_d = state_q;
    if (ce) begin
      // first stage is read only by the second
      state_d.sync1 = {run_enable, phase_60_sel, fwd_rev,
                       rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};
      state_d.sync2 = state_q.sync1;
      // set wins over the comparators: the ramp is low while discharging
      if (osc_set) begin
        state_d.upper = 1'b1;
        state_d.lower = 1'b1;
      end else begin
        state_d.upper = state_q.upper & ~pwm_cmp;
        state_d.lower = state_q.lower & ~cur_limit;
      end
      // latches only fall between sets, so one pulse per cycle at most
      state_d.bot = (drive_ok && state_q.upper && state_q.lower) ? bot_on : 3'h0;
      state_d.top_n = drive_ok ? ~top_on : 3'h7;
      // count cycles that current limit cut short
      if (state_q.lower && cur_limit && !osc_set) begin
        state_d.oc_count = state_q.oc_count + COUNT_W'(1);
      end
      // write path
      if (wr_go) begin
        state_d.bvalid = 1'b1;
        state_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]) begin
          state_d.allow = s_axi_wdata[CTRL_ALLOW_BIT];
        end
        // a write of any value to OC_COUNT_OFS clears the counter; a same-cycle cut still counts, so none is lost
        if (s_axi_awaddr == OC_COUNT_OFS) begin
          state_d.oc_count = (state_q.lower && cur_limit && !osc_set) ? COUNT_W'(1) : '0;
        end
      end else if (state_q.bvalid && s_axi_bready) begin
        state_d.bvalid = 1'b0;
      end
      // read path
      if (rd_go) begin
        state_d.rvalid = 1'b1;
        state_d.rdata = rd_word;
        state_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (state_q.rvalid && s_axi_rready) begin
        state_d.rvalid = 1'b0;
      end
    end
  end

  // single register stage; enable defaults high so an idle pin runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q.sync1 <= SYN_RST;
      state_q.sync2 <= SYN_RST;
      state_q.upper <= 1'b0;
      state_q.lower <= 1'b0;
      state_q.top_n <= 3'h7;
      state_q.bot <= 3'h0;
      state_q.allow <= CTRL_ALLOW_RST;
      state_q.oc_count <= '0;
      state_q.bvalid <= 1'b0;
      state_q.bresp <= RESP_OKAY;
      state_q.rvalid <= 1'b0;
      state_q.rresp <= RESP_OKAY;
      state_q.rdata <= 32'h0;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from flip-flops
  assign high_side_drive_a = state_q.top_n[0];
  assign high_side_drive_b = state_q.top_n[1];
  assign high_side_drive_c = state_q.top_n[2];
  assign low_side_drive_a = state_q.bot[0];
  assign low_side_drive_b = state_q.bot[1];
  assign low_side_drive_c = state_q.bot[2];
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rresp = state_q.rresp;
  assign s_axi_rdata = state_q.rdata;

  // checks on the drive, latch, synchronizer and clock enable behaviour
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_set_arms_latches:
    assert property (ce && osc_set |=> state_q.upper && state_q.lower)
      else $error("oscillator set did not arm both latches");

  a_pwm_clears_upper:
    assert property (ce && pwm_cmp && !osc_set |=> !state_q.upper)
      else $error("pwm comparator did not clear upper latch");

  a_cl_clears_lower:
    assert property (ce && cur_limit && !osc_set |=> !state_q.lower)
      else $error("current limit did not clear lower latch");

  a_lower_stays_off:
    assert property (!state_q.lower && !(ce && osc_set) |=> !state_q.lower)
      else $error("lower latch re-armed without oscillator set");

  a_bottom_needs_latch:
    assert property (ce && (!state_q.upper || !state_q.lower) |=> state_q.bot == 3'h0)
      else $error("bottom drive on with a latch cleared");

  a_one_top_one_bot:
    assert property ($onehot0(~state_q.top_n) && $onehot0(state_q.bot)
                     && ((~state_q.top_n & state_q.bot) == 3'h0))
      else $error("more than one drive per bank or same phase on both");

  a_coast_on_disable:
    assert property (ce && !state_q.sync2[SYN_EN] |=> state_q.top_n == 3'h7 && state_q.bot == 3'h0)
      else $error("drives not off with run enable low");

  a_cs_kills_drives:
    assert property (ce && cur_limit |=> state_q.top_n == 3'h7 && state_q.bot == 3'h0)
      else $error("drives not off with current sense high");

  a_uv_kills_drives:
    assert property (ce && (uv_supply || uv_ref) |=> state_q.top_n == 3'h7 && state_q.bot == 3'h0)
      else $error("drives not off under undervoltage");

  a_invalid_code_off:
    assert property (ce && step == 3'h0 |=> state_q.top_n == 3'h7 && state_q.bot == 3'h0)
      else $error("drives not off on invalid sensor code");

  a_top_ignores_pwm:
    assert property (ce && drive_ok && !state_q.upper |=> state_q.top_n != 3'h7)
      else $error("top drive chopped by pwm");

  a_sync_two_stage:
    assert property ((aresetn && ce) ##1 (aresetn && ce)
                     |=> state_q.sync2[SYN_EN] == $past(run_enable, 2))
      else $error("run enable not delayed by two stages");

  a_sensor_a_synced:
    assert property ((aresetn && ce) ##1 (aresetn && ce)
                     |=> state_q.sync2[SYN_A] == $past(rotor_sensor_a, 2))
      else $error("sensor a not delayed by two stages");

  a_ce_freezes_state:
    assert property (!ce |=> $stable(state_q))
      else $error("state moved with clock enable low");

  a_bad_code_dark:
    assert property (ce && (state_q.sync2[SYN_SEL] ? (code == 3'h5 || code == 3'h2)
                                                   : (code == 3'h7 || code == 3'h0))
                     |=> state_q.top_n == 3'h7 && state_q.bot == 3'h0)
      else $error("drives on with a broken sensor code");

  a_fwd_step_one:
    assert property (ce && drive_ok && state_q.sync2[SYN_SEL] && state_q.sync2[SYN_DIR]
                     && code == 3'h4 |=> state_q.top_n == 3'h6)
      else $error("forward step one does not drive top a");

  a_rev_step_one:
    assert property (ce && drive_ok && !state_q.sync2[SYN_SEL] && !state_q.sync2[SYN_DIR]
                     && code == 3'h4 |=> state_q.top_n == 3'h3)
      else $error("reverse step one does not drive top c");

  a_fwd_bottom_pair:
    assert property (ce && drive_ok && state_q.upper && state_q.lower && state_q.sync2[SYN_SEL]
                     && state_q.sync2[SYN_DIR] && code == 3'h6 |=> state_q.bot == 3'h4)
      else $error("forward step two does not drive bottom c");

  a_latches_enable_bottom:
    assert property (ce && drive_ok && state_q.upper && state_q.lower |=> state_q.bot != 3'h0)
      else $error("armed latches did not enable a bottom drive");

endmodule

`default_nettype wire

// file: bench/hall_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none

module hall_bridge_model (
  // position request and phasing
  input wire logic [2:0] step,
  input wire logic sel,
  // bridge drives from the block
  input wire logic hsa,
  input wire logic hsb,
  input wire logic hsc,
  input wire logic lsa,
  input wire logic lsb,
  input wire logic lsc,
  // hall lines and decoded switch states
  output logic sa,
  output logic sb,
  output logic sc,
  output logic [2:0] top_on,
  output logic [2:0] bot_on
);
  // index 1..6 are steps, 0 and 7 the two codes a broken sensor line gives
  localparam logic [2:0] C60 [0:7] = '{3'h5, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0, 3'h2};
  localparam logic [2:0] C120 [0:7] = '{3'h7, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h0};

  // hall codes are plain levels, switch states read as on = 1
  always_comb begin
    {sa, sb, sc} = sel ? C60[step] : C120[step];
    top_on = ~{hsa, hsb, hsc};
    bot_on = {lsa, lsb, lsc};
  end
endmodule

`default_nettype wire

// file: bench/test_bldc_commutation_pwm.sv
`timescale 1ns/1ps
`default_nettype none

module test_bldc_commutation_pwm
  import bldc_pkg::*;
;
  logic ce = 1;
  logic aclk = 0, aresetn = 0, fwd = 1, sel = 1, en = 1, osc = 0, pwm = 0, cur = 0;
  logic uvs = 0, uvr = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sa, sb, sc, hsa, hsb, hsc, lsa, lsb, lsc;
  logic [2:0] step = 3'h1, top_on, bot_on;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0, n_compared = 0;
  // forward pairs per step, one-hot with phase a as msb
  localparam logic [2:0] FT [1:6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4};
  localparam logic [2:0] FB [1:6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};

  bldc_commutation_pwm u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .rotor_sensor_a(sa), .rotor_sensor_b(sb), .rotor_sensor_c(sc), .fwd_rev(fwd),
    .phase_60_sel(sel), .run_enable(en), .osc_set(osc), .pwm_cmp(pwm), .cur_limit(cur),
    .uv_supply(uvs), .uv_ref(uvr), .high_side_drive_a(hsa), .high_side_drive_b(hsb),
    .high_side_drive_c(hsc), .low_side_drive_a(lsa), .low_side_drive_b(lsb),
    .low_side_drive_c(lsc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  hall_bridge_model u_model (.step(step), .sel(sel), .hsa(hsa), .hsb(hsb), .hsc(hsc),
    .lsa(lsa), .lsb(lsb), .lsc(lsc), .sa(sa), .sb(sb), .sc(sc), .top_on(top_on),
    .bot_on(bot_on));

  // 125 mhz clock
  initial forever #4 aclk = ~aclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_drv(input logic [2:0] t, input logic [2:0] b);
    chk("top", {29'h0, top_on}, {29'h0, t});
    chk("bottom", {29'h0, bot_on}, {29'h0, b});
  endtask

  // one discharge pulse, then enough edges for the bottom drives to follow
  task automatic pulse();
    osc <= 1'b1;
    cyc(1);
    osc <= 1'b0;
    cyc(3);
  endtask

  // inputs cross two sync stages and the output register before the pulse
  task automatic set_pos(input logic [2:0] st, input logic s, input logic dr);
    step <= st;
    sel <= s;
    fwd <= dr;
    cyc(4);
    pulse();
  endtask

  // master releases each valid as soon as it is taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (!(awready === 1'b1 && wready === 1'b1)) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_regs();
    axi_rd(STATUS_OFS);
    chk("enable sync", {31'h0, d[ST_EN_BIT]}, 32'h1);
    axi_rd(CTRL_OFS);
    chk("ctrl", d, {31'h0, CTRL_ALLOW_RST});
    axi_wr(CTRL_OFS, 32'h0);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    set_pos(3'h1, 1'b1, 1'b1);
    chk_drv(3'h0, 3'h0);
    axi_wr(STATUS_OFS, 32'h0);
    chk("ro bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(4'hC);
    chk("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_wr(CTRL_OFS, 32'h1);
    $display("test regs done");
  endtask

  // both phasings, both directions, all six steps
  task automatic t_steps();
    for (int m = 0; m < 4; m++) begin
      for (int st = 1; st < 7; st++) begin
        set_pos(st[2:0], m[1], m[0]);
        if (m[0]) chk_drv(FT[st], FB[st]);
        else chk_drv(FB[st], FT[st]);
      end
    end
    $display("test steps done");
  endtask

  task automatic t_latch();
    set_pos(3'h1, 1'b1, 1'b1);
    pwm <= 1'b1;
    cyc(3);
    chk_drv(3'h4, 3'h0);
    pwm <= 1'b0;
    cyc(3);
    chk_drv(3'h4, 3'h0);
    pulse();
    chk_drv(3'h4, 3'h1);
    cur <= 1'b1;
    cyc(2);
    chk_drv(3'h0, 3'h0);
    cur <= 1'b0;
    cyc(3);
    chk_drv(3'h4, 3'h0);
    pulse();
    chk_drv(3'h4, 3'h1);
    // current sense stood for two edges but cut only one cycle
    axi_rd(OC_COUNT_OFS);
    chk("cut cycles", d, 32'h1);
    $display("test latch done");
  endtask

  task automatic t_off();
    for (int i = 0; i < 4; i++) begin
      set_pos(i[0] ? 3'h7 : 3'h0, i[1], 1'b1);
      chk_drv(3'h0, 3'h0);
    end
    en <= 1'b0;
    set_pos(3'h1, 1'b1, 1'b1);
    chk_drv(3'h0, 3'h0);
    en <= 1'b1;
    set_pos(3'h1, 1'b1, 1'b1);
    uvs <= 1'b1;
    cyc(2);
    chk_drv(3'h0, 3'h0);
    uvs <= 1'b0;
    uvr <= 1'b1;
    cyc(2);
    chk_drv(3'h0, 3'h0);
    uvr <= 1'b0;
    $display("test off done");
  endtask

  // clock enable low freezes the drives; a reset in mid-run clears them and the counter
  task automatic t_hold();
    set_pos(3'h1, 1'b1, 1'b1);
    ce <= 1'b0;
    step <= 3'h2;
    cyc(6);
    chk_drv(3'h4, 3'h1);
    ce <= 1'b1;
    cyc(4);
    chk_drv(3'h2, 3'h1);
    aresetn <= 1'b0;
    cyc(2);
    chk_drv(3'h0, 3'h0);
    aresetn <= 1'b1;
    axi_rd(OC_COUNT_OFS);
    chk("count after reset", d, 32'h0);
    set_pos(3'h1, 1'b1, 1'b1);
    chk_drv(3'h4, 3'h1);
    $display("test hold done");
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    cyc(20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    cyc(6);
    aresetn <= 1'b1;
    t_regs();
    t_steps();
    t_latch();
    t_off();
    t_hold();
    finish_test();
  end
endmodule

`default_nettype wire
